// File: hw/dpc_pkg.sv
// constants shared by the power, clock and mute control block
package dpc_pkg;

  // control word: seven address bits then nine data bits
  localparam int DPC_WORD_W = 16;
  localparam int DPC_ADDR_W = 7;
  localparam int DPC_DATA_W = 9;

  // register addresses
  localparam logic [6:0] DPC_ADDR_CHANNEL_CONTROL = 7'h02;
  localparam logic [6:0] DPC_ADDR_INTERFACE_POWER = 7'h0A;
  localparam logic [6:0] DPC_ADDR_LEGACY_CONVERTER = 7'h0C;
  localparam logic [6:0] DPC_ADDR_FOURTH_PAIR = 7'h0F;

  // channel_control fields
  localparam int DPC_GLOBAL_PD_BIT = 2;
  // interface_power_control fields
  localparam int DPC_PAIR_DIS_LSB = 1;
  localparam int DPC_PAIR_DIS_MSB = 3;
  localparam int DPC_MASTER_PD_BIT = 4;
  localparam int DPC_ROLE_BIT = 5;
  localparam int DPC_RATIO_LSB = 6;
  localparam int DPC_RATIO_MSB = 8;
  // legacy_converter_control fields
  localparam int DPC_MUTE_OUT_MODE_BIT = 0;
  localparam int DPC_LEGACY_DECODE_DIS_BIT = 6;
  // fourth_pair_control fields
  localparam int DPC_PAIR4_DIS_BIT = 1;
  localparam int DPC_PAIR4_DECODE_DIS_BIT = 5;
  localparam int DPC_ZSEL_LSB = 6;
  localparam int DPC_ZSEL_MSB = 7;
  localparam int DPC_ZSEL_HI_BIT = 8;

  // reset values
  localparam logic DPC_GLOBAL_PD_RST = 1'b0;
  localparam logic [2:0] DPC_PAIR_DIS_RST = 3'h0;
  localparam logic DPC_MASTER_PD_RST = 1'b0;
  localparam logic DPC_ROLE_RST = 1'b0;
  localparam logic [2:0] DPC_RATIO_RST = 3'h2;
  localparam logic DPC_DECODE_DIS_RST = 1'b0;
  localparam logic DPC_PAIR4_DIS_RST = 1'b0;
  localparam logic [1:0] DPC_ZSEL_RST = 2'h1;
  localparam logic DPC_ZSEL_HI_RST = 1'b0;
  localparam logic DPC_MUTE_OUT_MODE_RST = 1'b1;

  // audio link
  localparam int DPC_PAIRS = 4;
  localparam int DPC_ZERO_RUN = 1024;
  localparam int DPC_BITS_PER_FRAME = 64;
  localparam int DPC_RATIO_W = 10;

  // master clock cycles per frame for each ratio code
  function automatic logic [9:0] dpc_ratio_cycles(input logic [2:0] code);
    logic [9:0] r;
    r = 10'h100;
    unique case (code)
      3'h0: r = 10'h080;
      3'h1: r = 10'h0C0;
      3'h2: r = 10'h100;
      3'h3: r = 10'h180;
      3'h4: r = 10'h200;
      3'h5: r = 10'h300;
      default: r = 10'h100;
    endcase
    return r;
  endfunction

endpackage

// File: hw/dpc_clkgen.sv
// frame and bit clock divider for interface master role
`timescale 1ns/100ps
module dpc_clkgen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [9:0] ratio_cycles,
  // generated clocks
  output logic frame_clk,
  output logic bit_clk
);
  import dpc_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic [3:0] bit_cnt;
    logic frame_clk;
    logic bit_clk;
  } dpc_cg_t;

  dpc_cg_t st, next_st;
  logic [3:0] bit_per;

  // bit period is 2..12 master cycles; the odd 3-cycle bit period of ratio code 1 gives uneven duty
  assign bit_per = ratio_cycles[9:6];

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st = '0;
    end else begin
      next_st.cnt = (st.cnt >= ratio_cycles - 10'h001) ? 10'h000 : st.cnt + 10'h001;
      next_st.bit_cnt = (st.bit_cnt >= bit_per - 4'h1) || (next_st.cnt == 10'h000) ?
        4'h0 : st.bit_cnt + 4'h1;
      next_st.frame_clk = next_st.cnt < {1'b0, ratio_cycles[9:1]};
      // high in the second half: frame edges then fall on bit clock falling edges
      next_st.bit_clk = next_st.bit_cnt >= {1'b0, bit_per[3:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign frame_clk = st.frame_clk;
  assign bit_clk = st.bit_clk;

  // frame period spans exactly the selected count
  property p_frame_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
      (run && $stable(ratio_cycles) && st.cnt == ratio_cycles - 10'h001) |=> st.cnt == 10'h000;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not wrap");

endmodule // dpc_clkgen

// File: hw/dpc_zero_det.sv
// per-pair zero sample run detector on the audio link clock
`timescale 1ns/100ps
module dpc_zero_det #(
  parameter int PAIRS = 4,
  parameter int RUN = 1024
) (
  // link clock and reset
  input wire logic clk_link,
  input wire logic rst_b,
  // audio link
  input wire logic frame_clk,
  input wire logic [PAIRS-1:0] din,
  // zero flags, link domain
  output logic [PAIRS-1:0] zero_flag
);
  import dpc_pkg::*;

  typedef struct packed {
    logic frame_d;
    logic [PAIRS-1:0] seen_one;
    logic [PAIRS-1:0][10:0] run_cnt;
    logic [PAIRS-1:0] flag;
  } dpc_zd_t;

  dpc_zd_t st, next_st;
  logic frame_edge;

  // each frame clock edge closes one channel sample
  assign frame_edge = frame_clk ^ st.frame_d;

  always_comb begin
    next_st = st;
    next_st.frame_d = frame_clk;
    for (int i = 0; i < PAIRS; i++) begin
      if (frame_edge) begin
        next_st.seen_one[i] = din[i];
        if (st.seen_one[i]) begin
          next_st.run_cnt[i] = 11'h000;
        end else if (st.run_cnt[i] < 11'(RUN)) begin
          next_st.run_cnt[i] = st.run_cnt[i] + 11'h001;
        end
      end else begin
        next_st.seen_one[i] = st.seen_one[i] | din[i];
      end
      next_st.flag[i] = next_st.run_cnt[i] == 11'(RUN);
    end
  end

  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign zero_flag = st.flag;

  // the pair 0 flag only stands on a full run of zero samples
  property p_flag_run;
    @(posedge clk_link) disable iff (!rst_b)
      st.flag[0] |-> st.run_cnt[0] == 11'(RUN);
  endproperty
  a_flag_run: assert property (p_flag_run) else $error("zero flag without full run");

endmodule // dpc_zero_det

// File: hw/dpc_top.sv
// power-down, interface role, clock ratio and mute pin decode control
`timescale 1ns/100ps
module dpc_top (
  // master clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // audio link clock (bit clock as seen at the pin)
  input wire logic clk_link,
  // three-wire control port
  input wire logic ctl_clk,
  input wire logic ctl_data,
  input wire logic ctl_latch,
  // audio link pins
  input wire logic frame_clk_i,
  output logic frame_clk_o,
  output logic frame_clk_oe,
  output logic bit_clk_o,
  output logic bit_clk_oe,
  input wire logic [dpc_pkg::DPC_PAIRS-1:0] din,
  // mute pin
  input wire logic mute_i,
  output logic mute_o,
  output logic mute_oe,
  // analog and datapath controls
  output logic [dpc_pkg::DPC_PAIRS-1:0] pair_power_en,
  output logic midrail_reference_en,
  output logic history_clear,
  output logic filter_init,
  output logic [dpc_pkg::DPC_PAIRS-1:0] softmute,
  output logic interface_role_select
);
  import dpc_pkg::*;

  typedef struct packed {
    // control pin synchronisers
    logic [2:0] ctl_s1;
    logic [2:0] ctl_s2;
    logic ctl_clk_d;
    logic ctl_latch_d;
    logic [15:0] shift;
    // register fields
    logic global_dac_powerdown;
    logic [2:0] pair_disable_field;
    logic master_powerdown;
    logic role;
    logic [2:0] ratio;
    logic legacy_decode_dis;
    logic mute_out_mode;
    logic pair4_disable;
    logic pair4_decode_dis;
    logic [1:0] zero_flag_select;
    logic zero_flag_select_hi;
    // mute and flag synchronisers
    logic mute_s1;
    logic mute_s2;
    logic [3:0] zf_s1;
    logic [3:0] zf_s2;
    logic gpd_d;
    // output flops
    logic [3:0] pair_en;
    logic midrail_en;
    logic hist_clear;
    logic filt_init;
    logic [3:0] smute;
    logic mute_drv;
    logic mute_en;
    logic clk_oe;
  } dpc_top_t;

  dpc_top_t st, next_st;

  logic gen_frame;
  logic gen_bit;
  logic [3:0] link_flags;
  logic [3:0] pair_disable_bits;
  logic mute_decode_disable;
  logic [2:0] zsel;
  logic [3:0] sel_mask;
  logic flag_cond;
  logic mute_level;
  logic [6:0] wr_addr;
  logic [8:0] wr_data;
  logic wr_strobe;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  dpc_clkgen u_clkgen (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(st.role && !st.master_powerdown),
    .ratio_cycles(dpc_ratio_cycles(st.ratio)),
    .frame_clk(gen_frame),
    .bit_clk(gen_bit)
  );

  dpc_zero_det #(
    .PAIRS(DPC_PAIRS),
    .RUN(DPC_ZERO_RUN)
  ) u_zero_det (
    .clk_link(clk_link),
    .rst_b(rst_b),
    .frame_clk(frame_clk_i),
    .din(din),
    .zero_flag(link_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  assign pair_disable_bits = {st.pair4_disable, st.pair_disable_field};
  assign mute_decode_disable = st.legacy_decode_dis | st.pair4_decode_dis;
  assign zsel = {st.zero_flag_select_hi, st.zero_flag_select};

  // pair selection shared by the input and output use of the pin
  always_comb begin
    sel_mask = 4'hF;
    unique case (zsel)
      3'h0: sel_mask = 4'hF;
      3'h1: sel_mask = 4'h1;
      3'h2: sel_mask = 4'h2;
      3'h3: sel_mask = 4'h4;
      3'h4: sel_mask = 4'h8;
      3'h5: sel_mask = 4'h3;
      3'h6: sel_mask = 4'h7;
      3'h7: sel_mask = 4'hC;
    endcase
  end

  // every selected flag must be high
  assign flag_cond = (st.zf_s2 & sel_mask) == sel_mask;

  // when driving, the pin level feeds back from our own flop
  assign mute_level = st.mute_out_mode ? st.mute_drv : st.mute_s2;

  assign wr_addr = st.shift[15:9];
  assign wr_data = st.shift[8:0];
  // word commits on the rising edge of the latch line
  assign wr_strobe = st.ctl_s2[2] && !st.ctl_latch_d;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // two flops on every pin before use
    next_st.ctl_s1 = {ctl_latch, ctl_data, ctl_clk};
    next_st.ctl_s2 = st.ctl_s1;
    next_st.ctl_clk_d = st.ctl_s2[0];
    next_st.ctl_latch_d = st.ctl_s2[2];
    next_st.mute_s1 = mute_i;
    next_st.mute_s2 = st.mute_s1;
    next_st.zf_s1 = link_flags;
    next_st.zf_s2 = st.zf_s1;
    next_st.gpd_d = st.global_dac_powerdown;

    // data shifts in msb first on control clock rising edge
    if (st.ctl_s2[0] && !st.ctl_clk_d) begin
      next_st.shift = {st.shift[14:0], st.ctl_s2[1]};
    end

    // register writes; a powerdown never touches these fields
    if (wr_strobe) begin
      unique case (wr_addr)
        DPC_ADDR_CHANNEL_CONTROL: begin
          next_st.global_dac_powerdown = wr_data[DPC_GLOBAL_PD_BIT];
        end
        DPC_ADDR_INTERFACE_POWER: begin
          next_st.pair_disable_field = wr_data[DPC_PAIR_DIS_MSB:DPC_PAIR_DIS_LSB];
          next_st.master_powerdown = wr_data[DPC_MASTER_PD_BIT];
          next_st.role = wr_data[DPC_ROLE_BIT];
          if (wr_data[DPC_RATIO_MSB:DPC_RATIO_MSB-1] != 2'h3) begin
            next_st.ratio = wr_data[DPC_RATIO_MSB:DPC_RATIO_LSB];
          end
        end
        DPC_ADDR_LEGACY_CONVERTER: begin
          next_st.legacy_decode_dis = wr_data[DPC_LEGACY_DECODE_DIS_BIT];
          next_st.mute_out_mode = wr_data[DPC_MUTE_OUT_MODE_BIT];
        end
        DPC_ADDR_FOURTH_PAIR: begin
          next_st.pair4_disable = wr_data[DPC_PAIR4_DIS_BIT];
          next_st.pair4_decode_dis = wr_data[DPC_PAIR4_DECODE_DIS_BIT];
          next_st.zero_flag_select = wr_data[DPC_ZSEL_MSB:DPC_ZSEL_LSB];
          next_st.zero_flag_select_hi = wr_data[DPC_ZSEL_HI_BIT];
        end
        default: begin
        end
      endcase
    end

    // power: master and global override the per-pair bits
    for (int i = 0; i < DPC_PAIRS; i++) begin
      next_st.pair_en[i] = !(st.master_powerdown || st.global_dac_powerdown ||
        pair_disable_bits[i]);
    end
    next_st.midrail_en = !st.master_powerdown;
    next_st.hist_clear = st.global_dac_powerdown || st.master_powerdown;
    // one-cycle pulse on the falling edge of the global powerdown bit
    next_st.filt_init = st.gpd_d && !st.global_dac_powerdown;

    // mute pin: drive the flag condition only in output mode
    next_st.mute_en = st.mute_out_mode;
    next_st.mute_drv = st.mute_out_mode && flag_cond;
    next_st.smute = mute_level ? (mute_decode_disable ? 4'hF : sel_mask) : 4'h0;

    // clock pins are ours only in master role
    next_st.clk_oe = st.role;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.global_dac_powerdown <= DPC_GLOBAL_PD_RST;
      st.pair_disable_field <= DPC_PAIR_DIS_RST;
      st.master_powerdown <= DPC_MASTER_PD_RST;
      st.role <= DPC_ROLE_RST;
      st.ratio <= DPC_RATIO_RST;
      st.legacy_decode_dis <= DPC_DECODE_DIS_RST;
      st.pair4_decode_dis <= DPC_DECODE_DIS_RST;
      st.pair4_disable <= DPC_PAIR4_DIS_RST;
      st.zero_flag_select <= DPC_ZSEL_RST;
      st.zero_flag_select_hi <= DPC_ZSEL_HI_RST;
      st.mute_out_mode <= DPC_MUTE_OUT_MODE_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign frame_clk_o = gen_frame;
  assign bit_clk_o = gen_bit;
  assign frame_clk_oe = st.clk_oe;
  assign bit_clk_oe = st.clk_oe;
  assign mute_o = st.mute_drv;
  assign mute_oe = st.mute_en;
  assign pair_power_en = st.pair_en;
  assign midrail_reference_en = st.midrail_en;
  assign history_clear = st.hist_clear;
  assign filter_init = st.filt_init;
  assign softmute = st.smute;
  assign interface_role_select = st.role;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_global_pd;
    @(posedge clk_sys) disable iff (!rst_b)
      st.global_dac_powerdown |=> st.pair_en == 4'h0;
  endproperty
  a_global_pd: assert property (p_global_pd) else $error("pair active in global powerdown");

  property p_history;
    @(posedge clk_sys) disable iff (!rst_b)
      (st.global_dac_powerdown && !wr_strobe) |=> st.hist_clear && $stable(st.ratio);
  endproperty
  a_history: assert property (p_history) else $error("history or settings wrong in powerdown");

  property p_filter_init;
    @(posedge clk_sys) disable iff (!rst_b)
      $fell(st.gpd_d) |-> st.filt_init ##1 !st.filt_init;
  endproperty
  a_filter_init: assert property (p_filter_init) else $error("filter init pulse wrong");

  property p_pair_disable;
    @(posedge clk_sys) disable iff (!rst_b)
      (!st.global_dac_powerdown && !st.master_powerdown) ##1 $stable(pair_disable_bits) |->
        st.pair_en == ~pair_disable_bits;
  endproperty
  a_pair_disable: assert property (p_pair_disable) else $error("pair enable mismatch");

  property p_master_pd;
    @(posedge clk_sys) disable iff (!rst_b)
      st.master_powerdown |=> !st.midrail_en && st.pair_en == 4'h0;
  endproperty
  a_master_pd: assert property (p_master_pd) else $error("master powerdown ignored");

  property p_role_oe;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(st.role) |=> frame_clk_oe && bit_clk_oe;
  endproperty
  a_role_oe: assert property (p_role_oe) else $error("clock pins not driven in master role");

  property p_ratio_reserved;
    @(posedge clk_sys) disable iff (!rst_b)
      st.ratio != 3'h6 && st.ratio != 3'h7;
  endproperty
  a_ratio_reserved: assert property (p_ratio_reserved) else $error("reserved ratio code held");

  property p_decode_dis;
    @(posedge clk_sys) disable iff (!rst_b)
      (mute_level && mute_decode_disable) |=> st.smute == 4'hF;
  endproperty
  a_decode_dis: assert property (p_decode_dis) else $error("decode disable did not mute all");

  property p_mute_out;
    @(posedge clk_sys) disable iff (!rst_b)
      (st.mute_out_mode && flag_cond) |=> st.mute_drv ##1 st.smute != 4'h0;
  endproperty
  a_mute_out: assert property (p_mute_out) else $error("mute output or self mute missing");

  property p_mute_in;
    @(posedge clk_sys) disable iff (!rst_b)
      (!st.mute_out_mode && st.mute_s2 && !mute_decode_disable) |=>
        st.smute == $past(sel_mask);
  endproperty
  a_mute_in: assert property (p_mute_in) else $error("wrong pairs muted");

  property p_mute_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !st.mute_out_mode |=> !mute_oe && !mute_o;
  endproperty
  a_mute_idle: assert property (p_mute_idle) else $error("mute pin driven");

  property p_clk_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !(st.role && !st.master_powerdown) |=> !frame_clk_o && !bit_clk_o;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clocks run while stopped");

  property p_slave_oe;
    @(posedge clk_sys) disable iff (!rst_b)
      !st.role |=> !frame_clk_oe && !bit_clk_oe;
  endproperty
  a_slave_oe: assert property (p_slave_oe) else $error("slave drives clocks");

endmodule // dpc_top

// File: testbench/dpc_audio_src.sv
// audio source model: link clock, frame clock and per-pair serial data
`timescale 1ns/100ps
module dpc_audio_src #(
  parameter int HALF_FRAME = 2
) (
  // bench control: pairs that send zero samples
  input wire logic [3:0] zero_mask,
  // link pins driven by the source
  output logic clk_link,
  output logic frame_clk,
  output logic [3:0] din
);
  int cnt;
  // source owns both clocks in slave role; offset keeps phase unrelated to clk_sys
  initial begin
    clk_link = 1'b0;
    frame_clk = 1'b0;
    din = 4'h0;
    cnt = 0;
    #7;
    forever #62.5 clk_link = ~clk_link;
  end
  // launch on the falling edge so the sampling edge sees settled lines
  always @(negedge clk_link) begin
    din <= ~zero_mask;
    cnt <= (cnt == HALF_FRAME - 1) ? 0 : cnt + 1;
    if (cnt == HALF_FRAME - 1) frame_clk <= ~frame_clk;
  end
endmodule // dpc_audio_src

// File: testbench/tb_dac_power_clock_mute_control.sv
// self-checking bench for the power, clock and mute control block
`timescale 1ns/100ps
module tb_dac_power_clock_mute_control;
  import dpc_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, ctl_clk = 1'b0, ctl_data = 1'b0, ctl_latch = 1'b0;
  logic mute_i = 1'b0;
  logic [3:0] src_zero = 4'h0;
  logic frame_clk_o, frame_clk_oe, bit_clk_o, bit_clk_oe, mute_o, mute_oe;
  logic midrail_reference_en, history_clear, filter_init, interface_role_select;
  logic [3:0] pair_power_en, softmute, din;
  wire logic clk_link, frame_clk_i, src_clk, src_frame;
  int miscompares = 0, check_count = 0, cyc = 0, init_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // in master role the generated clocks come back in at the pins
  assign clk_link = frame_clk_oe ? bit_clk_o : src_clk;
  assign frame_clk_i = frame_clk_oe ? frame_clk_o : src_frame;

  dpc_top DUT (.clk_sys, .rst_b, .clk_link, .ctl_clk, .ctl_data, .ctl_latch, .frame_clk_i,
    .frame_clk_o, .frame_clk_oe, .bit_clk_o, .bit_clk_oe, .din, .mute_i, .mute_o, .mute_oe,
    .pair_power_en, .midrail_reference_en, .history_clear, .filter_init, .softmute,
    .interface_role_select);

  dpc_audio_src src (.zero_mask(src_zero), .clk_link(src_clk), .frame_clk(src_frame), .din(din));

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (filter_init === 1'b1) init_cnt <= init_cnt + 1;
    if (cyc == 80000) begin
      miscompares++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  // three-wire write; each level held three clocks to clear the input sync
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    logic [15:0] w;
    w = {a, d};
    for (int i = 15; i >= 0; i--) begin
      ctl_clk <= 1'b0;
      ctl_data <= w[i];
      repeat (3) @(posedge clk_sys);
      ctl_clk <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    ctl_clk <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ctl_latch <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ctl_latch <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  // clocks between second and third rise; the first may still be an old frame
  task automatic period(input bit b, output int n);
    int r0, k;
    logic p, s;
    r0 = 0;
    k = 0;
    n = 0;
    p = 1'b1;
    for (int t = 0; t < 4000 && n == 0; t++) begin
      @(posedge clk_sys);
      s = b ? bit_clk_o : frame_clk_o;
      if (s === 1'b1 && p === 1'b0) k++;
      if (s === 1'b1 && p === 1'b0 && k == 2) r0 = t;
      if (s === 1'b1 && p === 1'b0 && k == 3) n = t - r0;
      p = s;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(pair_power_en, 4'hF, "pairs on");
    chk(midrail_reference_en, 1'b1, "midrail on");
    chk(interface_role_select, 1'b0, "slave role");
    chk(frame_clk_oe | bit_clk_oe, 1'b0, "clocks are inputs");
    chk(mute_oe, 1'b1, "mute pin output");
    chk(softmute, 4'h0, "no mute");
  endtask

  task automatic t_disable;
    logic [3:0] e;
    for (int i = 0; i < 3; i++) begin
      e = ~(4'h1 << i);
      wr(DPC_ADDR_INTERFACE_POWER, 9'h080 | (9'h002 << i));
      chk(pair_power_en, e, "pair disable");
    end
    wr(DPC_ADDR_INTERFACE_POWER, 9'h080);
    wr(DPC_ADDR_FOURTH_PAIR, 9'h042);
    wr(7'h03, 9'h1FF);
    chk(pair_power_en, 4'h7, "pair4 disable, unmapped ignored");
    wr(DPC_ADDR_FOURTH_PAIR, 9'h040);
    chk(pair_power_en, 4'hF, "pair4 back");
  endtask

  task automatic t_global;
    int n0;
    wr(DPC_ADDR_INTERFACE_POWER, 9'h084);
    wr(DPC_ADDR_CHANNEL_CONTROL, 9'h004);
    chk(pair_power_en, 4'h0, "global off");
    chk(history_clear, 1'b1, "history cleared");
    n0 = init_cnt;
    wr(DPC_ADDR_CHANNEL_CONTROL, 9'h000);
    chk(10'(init_cnt - n0), 10'h001, "filter init");
    chk(pair_power_en, 4'hD, "settings kept");
    chk(history_clear, 1'b0, "history released");
    wr(DPC_ADDR_INTERFACE_POWER, 9'h080);
  endtask

  // pairs go down first, then the master bit with the disables still set
  task automatic t_master_pd;
    wr(DPC_ADDR_INTERFACE_POWER, 9'h08E);
    wr(DPC_ADDR_FOURTH_PAIR, 9'h042);
    wr(DPC_ADDR_INTERFACE_POWER, 9'h09E);
    chk(midrail_reference_en, 1'b0, "midrail off");
    chk(pair_power_en, 4'h0, "override disables");
    wr(DPC_ADDR_INTERFACE_POWER, 9'h080);
    wr(DPC_ADDR_FOURTH_PAIR, 9'h040);
    chk({midrail_reference_en, pair_power_en}, 5'h1F, "power back");
  endtask

  task automatic t_master;
    logic [9:0] rat [6];
    int n;
    rat = '{10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h300};
    for (int c = 0; c < 6; c++) begin
      wr(DPC_ADDR_INTERFACE_POWER, {3'(c), 6'h20});
      period(1'b0, n);
      chk(10'(n), rat[c], "frame period");
      period(1'b1, n);
      chk(10'(n), rat[c] >> 6, "bit period");
    end
    chk(frame_clk_oe & bit_clk_oe & interface_role_select, 1'b1, "master drives");
    wr(DPC_ADDR_INTERFACE_POWER, 9'h1A0);
    period(1'b0, n);
    chk(10'(n), 10'h300, "reserved ratio kept");
    wr(DPC_ADDR_INTERFACE_POWER, 9'h080);
    chk(frame_clk_oe | bit_clk_oe | interface_role_select, 1'b0, "slave again");
  endtask

  // a sample ends on every frame edge, 12.5 clocks apart here
  task automatic t_zero;
    int t;
    src_zero <= 4'h1;
    for (t = 0; t < 20000 && mute_o !== 1'b1; t++) @(posedge clk_sys);
    chk(10'(t > 12000 && t < 14000), 10'h001, "zero run length");
    repeat (2) @(posedge clk_sys);
    chk(softmute, 4'h1, "pair1 muted");
    wr(DPC_ADDR_FOURTH_PAIR, 9'h080);
    chk({mute_o, softmute}, 5'h00, "flag2 not set");
    wr(DPC_ADDR_FOURTH_PAIR, 9'h040);
    wr(DPC_ADDR_LEGACY_CONVERTER, 9'h041);
    chk(softmute, 4'hF, "decode off, legacy bit");
    wr(DPC_ADDR_LEGACY_CONVERTER, 9'h001);
    wr(DPC_ADDR_FOURTH_PAIR, 9'h060);
    chk(softmute, 4'hF, "decode off, pair4 bit");
    wr(DPC_ADDR_FOURTH_PAIR, 9'h040);
    chk(softmute, 4'h1, "decode back on");
    src_zero <= 4'h0;
    repeat (40) @(posedge clk_sys);
    chk({mute_o, softmute}, 5'h00, "nonzero clears flag");
  endtask

  task automatic t_input;
    logic [3:0] m [8];
    m = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h7, 4'hC};
    wr(DPC_ADDR_LEGACY_CONVERTER, 9'h000);
    chk(mute_oe, 1'b0, "mute pin input");
    mute_i <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(DPC_ADDR_FOURTH_PAIR, {3'(c), 6'h00});
      chk(softmute, m[c], "input decode");
    end
    wr(DPC_ADDR_FOURTH_PAIR, 9'h060);
    chk(softmute, 4'hF, "input, decode off");
    mute_i <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(softmute, 4'h0, "input low");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset;
    t_disable;
    t_global;
    t_master_pd;
    t_master;
    t_zero;
    t_input;
    end_sim;
  end
endmodule // tb_dac_power_clock_mute_control
